// *** src/fcl_pkg.sv ***
// Package: constants and carrier types for the fan commutation and lock block
// Overview of operation
// RULE1: Hall edge restarts lock timing while running
// RULE2: Lock detection only after soft-start completes
// RULE3: No Hall edge in interval disables drive
// RULE4: Off interval, then automatic soft-start retry
// RULE5: No edge during soft-start returns to off
// RULE6: Edge seen during soft-start enters lock-detect
// RULE7: Each interval timed by its own rate; the code counts every interval at the clock rate, against its own cfg length
// RULE8: Current limit ramps zero to nominal in soft-start
// RULE9: Tach follows Hall, open-drain pull-down
// RULE10: Over-current backs off output PWM duty
// RULE11: Low-side outputs carry commutation and PWM
// RULE12: Inactive phase low-side output held low
// RULE13: High-side outputs commutation only, active low
// RULE14: Hall positive above negative selects phase two
// RULE15: Speed input duty sets low-side PWM duty
// RULE16: Reset starts soft-start with counters cleared
// RULE17: Interval lengths are cycle-count configuration inputs
package fcl_pkg;
  localparam int CNT_W     = 24;
  localparam int PWM_W     = 8;
  localparam int THR_W     = 8;
  localparam logic [PWM_W-1:0] PWM_ZERO    = 8'h00;
  localparam logic [PWM_W-1:0] PWM_BACKOFF = 8'h01;
  localparam logic [THR_W-1:0] THR_ZERO    = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 24'h000001;

  typedef enum logic [1:0] {
    FCL_SOFT,
    FCL_RUN,
    FCL_OFF
  } fcl_mode_t;

  typedef struct packed {
    logic [CNT_W-1:0] soft_len;
    logic [CNT_W-1:0] lock_len;
    logic [CNT_W-1:0] off_len;
  } fcl_cfg_t;

  typedef struct packed {
    logic phase_one_low_drive;
    logic phase_two_low_drive;
    logic phase_one_high_drive_oe_n;
    logic phase_two_high_drive_oe_n;
  } fcl_bridge_t;
endpackage

// *** src/fcl_pwm_meter.sv ***
// Module: measures speed input duty and regenerates an output PWM
`timescale 1ns/100ps
module fcl_pwm_meter #(
  parameter int PWM_W = fcl_pkg::PWM_W
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             speed_in,
  input  wire logic             backoff,
  output logic                  pwm_out,
  output logic [PWM_W-1:0]      duty
);
  typedef struct packed {
    logic [PWM_W-1:0] phase;
    logic [PWM_W-1:0] high_cnt;
    logic [PWM_W-1:0] duty;
    logic             pwm;
  } fcl_meter_t;

  fcl_meter_t st_reg;
  fcl_meter_t st_next;

  // Duty measured over one free-running 256-cycle frame, so only inputs faster than the frame average out
  always_comb begin
    st_next = st_reg;
    st_next.phase = st_reg.phase + 1'b1;
    if (speed_in) begin
      st_next.high_cnt = st_reg.high_cnt + 1'b1;
    end
    if (&st_reg.phase) begin
      st_next.high_cnt = {PWM_W{1'b0}};
      // Saturate: a frame of all-high samples would otherwise wrap to zero duty
      st_next.duty = (speed_in && !(&st_reg.high_cnt)) ? st_reg.high_cnt + 1'b1 : st_reg.high_cnt; // RULE15
    end else if (backoff && st_reg.duty != fcl_pkg::PWM_ZERO) begin
      st_next.duty = st_reg.duty - fcl_pkg::PWM_BACKOFF; // RULE10
    end
    // Full-scale duty holds the output on for a true full-speed drive
    st_next.pwm = ((st_reg.phase < st_reg.duty) || (&st_reg.duty)) && !backoff; // RULE15 RULE10
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwm_out = st_reg.pwm;
  assign duty    = st_reg.duty;
endmodule

// *** src/fcl_top.sv ***
// Module: single-phase fan commutation, lock supervision and soft-start
`timescale 1ns/100ps
module fcl_top (
  input  wire logic                         clock,
  input  wire logic                         arst_n,
  input  wire logic                         hall_pos,
  input  wire logic                         hall_neg,
  input  wire logic                         speed_pwm_input,
  input  wire logic                         sense_over,
  input  wire logic [fcl_pkg::THR_W-1:0]    current_limit_nominal,
  input  fcl_pkg::fcl_cfg_t                 cfg, // RULE17
  output fcl_pkg::fcl_bridge_t              bridge,
  output logic                              tach_output_oe_n,
  output logic [fcl_pkg::THR_W-1:0]         current_limit_threshold,
  output fcl_pkg::fcl_mode_t                mode
);
  typedef struct packed {
    logic [1:0]               hp_sync;
    logic [1:0]               hn_sync;
    logic [1:0]               spd_sync;
    logic [1:0]               ov_sync;
    logic                     hall_last;
    logic [2:0]               prime;
    logic                     seen_edge;
    fcl_pkg::fcl_mode_t       mode;
    logic [fcl_pkg::CNT_W-1:0] cnt;
    logic [fcl_pkg::THR_W-1:0] thr;
    fcl_pkg::fcl_bridge_t     br;
    logic                     tach_oe_n;
  } fcl_state_t;

  fcl_state_t st_reg;
  fcl_state_t st_next;
  logic       pwm_raw;
  logic       hall_now;
  logic       hall_edge;
  logic       drive_on;
  logic       over;

  assign hall_now  = st_reg.hp_sync[1] & ~st_reg.hn_sync[1]; // RULE14
  // Masked until the synchronisers hold a real Hall level, so reset gives no false edge
  assign hall_edge = st_reg.prime[2] & (hall_now ^ st_reg.hall_last);
  assign over      = st_reg.ov_sync[1] && (st_reg.mode != fcl_pkg::FCL_OFF);

  fcl_pwm_meter #(
    .PWM_W (fcl_pkg::PWM_W)
  ) u_meter (
    .clock    (clock),
    .arst_n   (arst_n),
    .speed_in (st_reg.spd_sync[1]),
    .backoff  (over),
    .pwm_out  (pwm_raw),
    .duty     ()
  );

  // Ramp step scaled so the threshold reaches nominal as soft-start ends
  function automatic logic [fcl_pkg::THR_W-1:0] ramp(
    input logic [fcl_pkg::CNT_W-1:0] c,
    input logic [fcl_pkg::CNT_W-1:0] len,
    input logic [fcl_pkg::THR_W-1:0] nom
  );
    logic [fcl_pkg::CNT_W+fcl_pkg::THR_W-1:0] prod;
    prod = c * nom;
    if (len == fcl_pkg::CNT_ZERO || c >= len) begin
      ramp = nom;
    end else begin
      ramp = fcl_pkg::THR_W'(prod / len);
    end
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.hp_sync  = {st_reg.hp_sync[0], hall_pos};
    st_next.hn_sync  = {st_reg.hn_sync[0], hall_neg};
    st_next.spd_sync = {st_reg.spd_sync[0], speed_pwm_input};
    st_next.ov_sync  = {st_reg.ov_sync[0], sense_over};
    st_next.hall_last = hall_now;
    st_next.prime     = {st_reg.prime[1:0], 1'b1};
    st_next.cnt = st_reg.cnt + fcl_pkg::CNT_ONE;
    drive_on = 1'b1;
    case (st_reg.mode)
      fcl_pkg::FCL_SOFT: begin
        if (hall_edge) begin
          st_next.seen_edge = 1'b1;
        end
        st_next.thr = ramp(st_reg.cnt, cfg.soft_len, current_limit_nominal); // RULE8
        if (st_reg.cnt + fcl_pkg::CNT_ONE >= cfg.soft_len) begin // RULE7
          st_next.cnt = fcl_pkg::CNT_ZERO;
          st_next.thr = current_limit_nominal;
          if (st_reg.seen_edge || hall_edge) begin
            st_next.mode = fcl_pkg::FCL_RUN; // RULE6 RULE2
          end else begin
            st_next.mode = fcl_pkg::FCL_OFF; // RULE5
          end
        end
      end
      fcl_pkg::FCL_RUN: begin
        st_next.thr = current_limit_nominal;
        if (hall_edge) begin
          st_next.cnt = fcl_pkg::CNT_ZERO; // RULE1
        end else if (st_reg.cnt + fcl_pkg::CNT_ONE >= cfg.lock_len) begin // RULE7
          st_next.cnt  = fcl_pkg::CNT_ZERO;
          st_next.mode = fcl_pkg::FCL_OFF; // RULE3
        end
      end
      fcl_pkg::FCL_OFF: begin
        drive_on = 1'b0; // RULE4
        st_next.thr = fcl_pkg::THR_ZERO;
        if (st_reg.cnt + fcl_pkg::CNT_ONE >= cfg.off_len) begin // RULE7
          st_next.cnt       = fcl_pkg::CNT_ZERO;
          st_next.seen_edge = 1'b0;
          st_next.mode      = fcl_pkg::FCL_SOFT; // RULE4
        end
      end
      default: begin
        st_next.mode = fcl_pkg::FCL_OFF;
        st_next.cnt  = fcl_pkg::CNT_ZERO;
      end
    endcase
    if (st_next.mode == fcl_pkg::FCL_OFF) begin
      drive_on = 1'b0; // RULE3 RULE5
      st_next.thr = fcl_pkg::THR_ZERO; // RULE8
    end
    // Outputs follow the next mode so lock shutdown is not a cycle late
    st_next.br.phase_two_low_drive = drive_on && hall_now && pwm_raw; // RULE11 RULE12
    st_next.br.phase_one_low_drive = drive_on && !hall_now && pwm_raw; // RULE11 RULE12
    st_next.br.phase_two_high_drive_oe_n = !(drive_on && hall_now); // RULE13
    st_next.br.phase_one_high_drive_oe_n = !(drive_on && !hall_now); // RULE13
    st_next.tach_oe_n = hall_now; // RULE9
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0; // RULE16
      st_reg.mode <= fcl_pkg::FCL_SOFT; // RULE16
      st_reg.br.phase_one_high_drive_oe_n <= 1'b1;
      st_reg.br.phase_two_high_drive_oe_n <= 1'b1;
      st_reg.tach_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bridge                  = st_reg.br;
  assign tach_output_oe_n        = st_reg.tach_oe_n;
  assign current_limit_threshold = st_reg.thr;
  assign mode                    = st_reg.mode;
endmodule

// *** test/fcl_top_props.sv ***
// Property checker for the fan commutation and lock block
`timescale 1ns/100ps
module fcl_top_props (
  input wire logic                      clock,
  input wire logic                      arst_n,
  input wire logic                      hall_pos,
  input wire logic                      hall_neg,
  input wire logic                      speed_pwm_input,
  input wire logic                      sense_over,
  input wire logic [fcl_pkg::THR_W-1:0] current_limit_nominal,
  input fcl_pkg::fcl_cfg_t              cfg,
  input fcl_pkg::fcl_bridge_t           bridge,
  input wire logic                      tach_output_oe_n,
  input wire logic [fcl_pkg::THR_W-1:0] current_limit_threshold,
  input fcl_pkg::fcl_mode_t             mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_off_leave; mode == fcl_pkg::FCL_OFF ##1 mode != fcl_pkg::FCL_OFF; endsequence
  sequence s_run_leave; mode == fcl_pkg::FCL_RUN ##1 mode != fcl_pkg::FCL_RUN; endsequence
  sequence s_over; sense_over [*5] ##0 mode == fcl_pkg::FCL_RUN; endsequence
  property p_off_quiet; mode == fcl_pkg::FCL_OFF |-> bridge == 4'h3; endproperty
  property p_off_next; s_off_leave |-> mode == fcl_pkg::FCL_SOFT; endproperty
  property p_run_exit; s_run_leave |-> mode == fcl_pkg::FCL_OFF; endproperty
  property p_run_entry;
    mode == fcl_pkg::FCL_RUN && $past(mode) != fcl_pkg::FCL_RUN |-> $past(mode) == fcl_pkg::FCL_SOFT;
  endproperty
  property p_hi_excl; !(!bridge.phase_one_high_drive_oe_n && !bridge.phase_two_high_drive_oe_n); endproperty
  property p_lo_excl; !(bridge.phase_one_low_drive && bridge.phase_two_low_drive); endproperty
  property p_thr_cap; mode == fcl_pkg::FCL_SOFT |-> current_limit_threshold <= current_limit_nominal; endproperty
  property p_thr_rise;
    mode == fcl_pkg::FCL_SOFT && $past(mode) == fcl_pkg::FCL_SOFT |->
      current_limit_threshold >= $past(current_limit_threshold);
  endproperty
  property p_off_thr; mode == fcl_pkg::FCL_OFF |-> current_limit_threshold == 8'h00; endproperty
  property p_over; s_over |-> !bridge.phase_one_low_drive && !bridge.phase_two_low_drive; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("drive active while off");
  a_off_next: assert property (p_off_next) else $error("off left to wrong state");
  a_run_exit: assert property (p_run_exit) else $error("run left to wrong state");
  a_run_entry: assert property (p_run_entry) else $error("run entered not from soft-start");
  a_hi_excl: assert property (p_hi_excl) else $error("both high sides pulled");
  a_lo_excl: assert property (p_lo_excl) else $error("both low sides on");
  a_thr_cap: assert property (p_thr_cap) else $error("threshold above nominal");
  a_thr_rise: assert property (p_thr_rise) else $error("threshold fell in soft-start");
  a_off_thr: assert property (p_off_thr) else $error("threshold not zero while off");
  a_over: assert property (p_over) else $error("low side on during over-current");
endmodule
bind fcl_top fcl_top_props u_props (.*);

// *** test/fcl_hall_model.sv ***
// Hall sensor model: complementary outputs, toggling while the rotor spins
`timescale 1ns/100ps
module fcl_hall_model (
  input wire logic clock,
  input wire logic spin,
  output logic     hall_pos,
  output logic     hall_neg
);
  int n = 0;
  initial hall_pos = 1'b0;
  assign hall_neg = ~hall_pos;
  // A stalled rotor holds its last magnet position
  always @(negedge clock) begin
    if (spin) begin
      n <= (n == 7) ? 0 : n + 1;
      if (n == 7) hall_pos <= ~hall_pos;
    end
  end
endmodule

// *** test/fcl_top_tb.sv ***
// Self-checking testbench for the fan commutation and lock block
`timescale 1ns/100ps
module fcl_top_tb;
  logic                 clock = 0, arst_n = 0, spin = 0, speed = 1, sense_over = 0, hall_pos, hall_neg, tach;
  logic [7:0]           thr;
  fcl_pkg::fcl_bridge_t bridge;
  fcl_pkg::fcl_mode_t   mode;
  int                   num_errors = 0, tests_run = 0, n;
  logic [31:0]          k;
  always #20 clock = ~clock;
  fcl_hall_model hall (.clock(clock), .spin(spin), .hall_pos(hall_pos), .hall_neg(hall_neg));
  fcl_top dut (.clock(clock), .arst_n(arst_n), .hall_pos(hall_pos), .hall_neg(hall_neg),
    .speed_pwm_input(speed), .sense_over(sense_over), .current_limit_nominal(8'hC8),
    .cfg({24'h000014, 24'h000028, 24'h00001E}), .bridge(bridge), .tach_output_oe_n(tach),
    .current_limit_threshold(thr), .mode(mode));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wait_mode(input fcl_pkg::fcl_mode_t m);
    n = 0;
    while (mode !== m && n < 200) begin
      @(negedge clock);
      n++;
    end
  endtask
  task count_on;
    k = 0;
    repeat (256) begin
      @(negedge clock);
      k += 32'(bridge.phase_one_low_drive | bridge.phase_two_low_drive);
    end
  endtask
  task t_reset;
    chk(mode, fcl_pkg::FCL_SOFT);
    chk({bridge, tach, thr}, 13'h0700);
  endtask
  task t_locked;
    wait_mode(fcl_pkg::FCL_OFF);
    chk(n >= 20 && n <= 23, 1);
    chk(bridge, 4'h3);
    chk(thr, 8'h00);
    wait_mode(fcl_pkg::FCL_SOFT);
    chk(n >= 30 && n <= 31, 1);
  endtask
  task t_spin;
    spin <= 1'b1;
    repeat (10) @(negedge clock);
    chk(thr > 8'h00 && thr < 8'hC8, 1);
    wait_mode(fcl_pkg::FCL_RUN);
    chk(mode, fcl_pkg::FCL_RUN);
    chk(thr, 8'hC8);
    repeat (300) @(negedge clock);
    chk(mode, fcl_pkg::FCL_RUN);
  endtask
  task t_pwm;
    count_on;
    chk(k >= 200, 1);
    @(posedge hall_pos);
    repeat (4) @(negedge clock);
    chk({bridge, tach}, 5'h0D);
    @(negedge hall_pos);
    sense_over = 1;
    repeat (6) @(negedge clock);
    chk({bridge, tach}, 5'h02);
    sense_over = 0;
    speed = 0;
    repeat (600) @(negedge clock);
    count_on;
    chk(k, 0);
  endtask
  task t_stall;
    spin <= 1'b0;
    wait_mode(fcl_pkg::FCL_OFF);
    chk(n >= 30 && n <= 46, 1);
  endtask
  initial begin
    repeat (20) @(negedge clock);
    t_reset;
    arst_n = 1;
    t_locked;
    t_spin;
    t_pwm;
    t_stall;
    results;
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results;
  end
endmodule
